/* File: shared/rsl_pkg.sv */
/*
 Package for the reset strap latch: strap bit positions, reset values,
 decoded mode enumerations and the packed carriers shared by the design.
 Assumes a single 200 MHz clock domain and a synchronous active-high reset.
*/
package rsl_pkg;

    // Number of strap inputs
    localparam int RSL_NUM_STRAPS = 5;

    // Bit positions in the strap status word
    localparam int RSL_BIT_LDO  = 0;
    localparam int RSL_BIT_BOOT = 1;
    localparam int RSL_BIT_SEC  = 2;
    localparam int RSL_BIT_LOG  = 3;
    localparam int RSL_BIT_SDIO = 4;

    // Value of the strap word before any capture (the pull defaults)
    localparam logic [4:0] RSL_STRAP_RESET = 5'h1A;

    // Pull direction per strap while reset holds: 1 = pull-up, 0 = pull-down
    localparam logic [4:0] RSL_PULL_UP_MASK = 5'h1A;

    // Clock period and minimum chip-enable low time
    localparam int RSL_CLK_PERIOD_PS = 5000;
    localparam int RSL_CE_LOW_MIN_NS = 50000;
    localparam int RSL_CE_LOW_CYCLES = (RSL_CE_LOW_MIN_NS * 1000 + RSL_CLK_PERIOD_PS - 1)
                                       / RSL_CLK_PERIOD_PS;

    // Boot source decoded from straps
    typedef enum logic [2:0] {
        RSL_BOOT_FLASH    = 3'h1,
        RSL_BOOT_DOWNLOAD = 3'h2,
        RSL_BOOT_INVALID  = 3'h4
    } rsl_boot_e;

    // Regulator output level
    typedef enum logic [1:0] {
        RSL_LDO_3V3 = 2'h1,
        RSL_LDO_1V8 = 2'h2
    } rsl_ldo_e;

    // Firmware override controls
    typedef struct packed {
        logic ldo_ovr_en;     // Use ldo_ovr_1v8 instead of the strap
        logic ldo_ovr_1v8;    // Override level, 1 = 1.8 V
        logic sdio_ovr_en;    // Use sdio_ovr_edges instead of the straps
        logic [1:0] sdio_ovr_edges; // {sample_rising, output_rising}
        logic ldo_power_off;  // Switch the regulator off
    } rsl_ctrl_s;

    // Decoded configuration handed to boot logic
    typedef struct packed {
        rsl_boot_e boot_src;
        logic      ldo_enable;
        rsl_ldo_e  ldo_level;
        logic      log_enable;
        logic      sdio_sample_rising;
        logic      sdio_output_rising;
    } rsl_cfg_s;

    // Decode while the block itself is in reset: matches the pull defaults
    localparam rsl_cfg_s RSL_CFG_RESET = '{RSL_BOOT_FLASH, 1'b1, RSL_LDO_3V3, 1'b1, 1'b1, 1'b1};

endpackage

/* File: hdl/rsl_ce_filter.sv */
/*
 Chip-enable qualifier: counts how long chip_enable_in has stayed low and
 asserts a system reset request once it has been low for the minimum time.
 Assumes chip_enable_in is synchronous to clock.
*/
`timescale 1ns/10ps
module rsl_ce_filter
    import rsl_pkg::*;
#(
    parameter int LOW_CYCLES = RSL_CE_LOW_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Pin side
    input  wire logic chip_enable_in,
    // Qualified reset request, held while the chip is in reset
    output logic      sys_reset
);

    localparam int CW = $clog2(LOW_CYCLES + 1);

    // Elaboration check: a zero count would let any glitch reset the chip
    if (LOW_CYCLES < 1) begin : g_bad_low_cycles
        $error("LOW_CYCLES must be at least one");
    end

    logic [CW-1:0] low_count;   // Cycles the pin has stayed low

    // Count low time; a short glitch low does not reset the chip
    always_ff @(posedge clock) begin
        if (rst || chip_enable_in) begin
            low_count <= '0;
        end else if (low_count != CW'(LOW_CYCLES)) begin
            low_count <= low_count + CW'(1);
        end
    end

    // Reset stays asserted from qualification until the pin rises again
    always_ff @(posedge clock) begin
        if (rst) begin
            sys_reset <= 1'b1;
        end else if (chip_enable_in) begin
            sys_reset <= 1'b0;
        end else if (low_count == CW'(LOW_CYCLES)) begin
            sys_reset <= 1'b1;
        end
    end

endmodule // rsl_ce_filter

/* File: hdl/rsl_strap_latch.sv */
/*
 Reset strap latch: samples five strap pins when system reset is released,
 holds them, decodes boot source, regulator level, boot log and SDIO edges,
 and lets firmware override the regulator and SDIO settings.
 Assumes all inputs are synchronous to clock; pin pads resolve pulls.
*/
// Summary of operation
// [R1] Latch straps once at reset release
// [R2] All five latched bits readable together
// [R3] Weak pulls enabled while reset holds
// [R4] Pins return to function; latch frozen
// [R5] Voltage strap 1 gives 1.8 V
// [R6] Boot strap decides flash or download boot
// [R7] Log strap enables boot log on serial
// [R8] Log and fifth strap set SDIO edges
// [R9] Firmware overrides beat latched strap values
// [R10] Software can switch regulator off
// [R11] Host waits 50 us after rails
// [R12] Host holds chip enable low 50 us
// [R13] Board drives voltage strap high for 1.8 V
// [R14] Status bits ordered voltage, boot, second, log, fifth
`timescale 1ns/10ps
module rsl_strap_latch
    import rsl_pkg::*;
#(
    parameter int CE_LOW_CYCLES = RSL_CE_LOW_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Chip enable and reset cause
    input  wire logic        chip_enable_in,
    input  wire logic        wdt_reset,          // RTC watchdog reset request
    input  wire logic        brownout_reset,     // Brownout reset request
    // Strap pin inputs
    input  wire logic        ldo_voltage_strap,
    input  wire logic        primary_boot_strap,
    input  wire logic        secondary_boot_strap,
    input  wire logic        log_timing_strap,
    input  wire logic        sdio_edge_strap,
    // Pad pull controls
    output logic [4:0]       pull_up_en,
    output logic [4:0]       pull_down_en,
    output logic             pins_functional,
    // Firmware controls
    input  wire rsl_ctrl_s   ctrl,
    // Status and decoded configuration
    output logic [4:0]       strap_status,       // [R2]
    output rsl_cfg_s         cfg,
    output logic             in_reset,
    // Boot log gate for the first serial transmitter
    input  wire logic        log_tx_data,
    input  wire logic        boot_done,
    output logic             first_serial_tx
);

    logic ce_reset;       // Qualified chip-enable reset
    logic sys_rst;        // Any reset cause
    logic sys_rst_d;      // Previous cycle of sys_rst
    logic [4:0] pins;     // Strap pins gathered into one word
    logic booting;        // Between reset release and boot_done

    // Elaboration check: a zero count would let any glitch reset the chip
    if (CE_LOW_CYCLES < 1) begin : g_bad_ce_cycles
        $error("CE_LOW_CYCLES must be at least one");
    end

    // Chip-enable low-time qualifier; host keeps the low time [R12]
    rsl_ce_filter #(
        .LOW_CYCLES     (CE_LOW_CYCLES)
    ) u_ce_filter (
        .clock          (clock),
        .rst            (rst),
        .chip_enable_in (chip_enable_in),
        .sys_reset      (ce_reset)
    );

    // Any of chip-enable, watchdog or brownout holds the system in reset
    assign sys_rst  = ce_reset | wdt_reset | brownout_reset;
    assign in_reset = sys_rst;

    // Status word packing order [R14]
    assign pins = {sdio_edge_strap, log_timing_strap, secondary_boot_strap,
                   primary_boot_strap, ldo_voltage_strap};

    // Delay reset so the release edge can be seen
    always_ff @(posedge clock) begin
        if (rst) begin
            sys_rst_d <= 1'b1;
        end else begin
            sys_rst_d <= sys_rst;
        end
    end

    // Capture only on the release edge, hold until next reset release
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_status <= RSL_STRAP_RESET;
        end else if (sys_rst_d && !sys_rst) begin
            strap_status <= pins; // [R1]
        end
        // Later pin activity leaves the latch untouched [R4]
    end

    // Pulls on during reset, pins functional afterwards
    always_ff @(posedge clock) begin
        if (rst || sys_rst) begin
            pull_up_en      <= RSL_PULL_UP_MASK;  // [R3]
            pull_down_en    <= ~RSL_PULL_UP_MASK; // [R3]
            pins_functional <= 1'b0;
        end else begin
            pull_up_en      <= 5'h00;
            pull_down_en    <= 5'h00;
            pins_functional <= 1'b1; // [R4]
        end
    end

    // Booting window for the log gate
    always_ff @(posedge clock) begin
        if (rst || sys_rst) begin
            booting <= 1'b1;
        end else if (boot_done) begin
            booting <= 1'b0;
        end
    end

    // Decode of the latched bits with firmware overrides
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg <= RSL_CFG_RESET;
        end else begin
            // Boot source from the two boot straps
            if (strap_status[RSL_BIT_BOOT]) begin
                cfg.boot_src <= RSL_BOOT_FLASH; // [R6]
            end else if (!strap_status[RSL_BIT_SEC]) begin
                cfg.boot_src <= RSL_BOOT_DOWNLOAD; // [R6]
            end else begin
                cfg.boot_src <= RSL_BOOT_INVALID;
            end
            cfg.ldo_enable <= !ctrl.ldo_power_off; // [R10]
            // Override wins over the strap [R9]
            if (ctrl.ldo_ovr_en) begin
                cfg.ldo_level <= ctrl.ldo_ovr_1v8 ? RSL_LDO_1V8 : RSL_LDO_3V3;
            end else begin
                cfg.ldo_level <= strap_status[RSL_BIT_LDO] ? RSL_LDO_1V8 : RSL_LDO_3V3; // [R5]
            end
            cfg.log_enable <= strap_status[RSL_BIT_LOG]; // [R7]
            if (ctrl.sdio_ovr_en) begin
                cfg.sdio_sample_rising <= ctrl.sdio_ovr_edges[1]; // [R9]
                cfg.sdio_output_rising <= ctrl.sdio_ovr_edges[0]; // [R9]
            end else begin
                cfg.sdio_sample_rising <= strap_status[RSL_BIT_LOG];  // [R8]
                cfg.sdio_output_rising <= strap_status[RSL_BIT_SDIO]; // [R8]
            end
        end
    end

    // Silent line idles high; while booting, log passes only if enabled
    always_ff @(posedge clock) begin
        if (rst) begin
            first_serial_tx <= 1'b1;
        end else if (booting && !strap_status[RSL_BIT_LOG]) begin
            first_serial_tx <= 1'b1; // [R7]
        end else begin
            first_serial_tx <= log_tx_data;
        end
    end

    // Assertions
    property p_latch_on_release;
        @(posedge clock) disable iff (rst)
        ($fell(sys_rst) && !$past(rst)) |=> strap_status == $past(pins);
    endproperty
    a_latch_on_release: assert property (p_latch_on_release) // [R1]
        else $error("straps not latched at reset release");

    property p_latch_hold;
        @(posedge clock) disable iff (rst)
        (!sys_rst && !sys_rst_d) |=> $stable(strap_status);
    endproperty
    a_latch_hold: assert property (p_latch_hold) // [R4]
        else $error("strap latch changed outside release");

    property p_pulls;
        @(posedge clock) disable iff (rst)
        sys_rst |=> pull_up_en == 5'h1A && pull_down_en == 5'h05 && !pins_functional;
    endproperty
    a_pulls: assert property (p_pulls) // [R3]
        else $error("pulls wrong during reset");

    property p_ldo;
        @(posedge clock) disable iff (rst)
        (!ctrl.ldo_ovr_en && strap_status[0]) |=> cfg.ldo_level == RSL_LDO_1V8;
    endproperty
    a_ldo: assert property (p_ldo) // [R5]
        else $error("regulator level does not follow strap");

    property p_boot;
        @(posedge clock) disable iff (rst)
        strap_status[1] |=> cfg.boot_src == RSL_BOOT_FLASH;
    endproperty
    a_boot: assert property (p_boot) // [R6]
        else $error("flash boot not selected");

    property p_silent;
        @(posedge clock) disable iff (rst)
        (booting && !strap_status[3]) |=> first_serial_tx;
    endproperty
    a_silent: assert property (p_silent) // [R7]
        else $error("serial line toggled while silenced");

    property p_sdio_edges;
        @(posedge clock) disable iff (rst)
        !ctrl.sdio_ovr_en |=> cfg.sdio_sample_rising == $past(strap_status[3])
                              && cfg.sdio_output_rising == $past(strap_status[4]);
    endproperty
    a_sdio_edges: assert property (p_sdio_edges) // [R8]
        else $error("SDIO edges do not follow straps");

    property p_ovr;
        @(posedge clock) disable iff (rst)
        (ctrl.ldo_ovr_en && ctrl.ldo_ovr_1v8) |=> cfg.ldo_level == RSL_LDO_1V8;
    endproperty
    a_ovr: assert property (p_ovr) // [R9]
        else $error("override did not win");

    property p_off;
        @(posedge clock) disable iff (rst)
        ctrl.ldo_power_off |=> !cfg.ldo_enable;
    endproperty
    a_off: assert property (p_off) // [R10]
        else $error("regulator not switched off");

    c_release: cover property (@(posedge clock) disable iff (rst) $fell(sys_rst));
    c_download: cover property (@(posedge clock) disable iff (rst)
        cfg.boot_src == RSL_BOOT_DOWNLOAD);
    c_override: cover property (@(posedge clock) disable iff (rst) ctrl.sdio_ovr_en);

endmodule // rsl_strap_latch

/* File: verif/rsl_board_model.sv */
/*
 Board or host model: drives the five strap pins and the chip enable pin.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/10ps
module rsl_board_model
    import rsl_pkg::*;
(
    // Clock
    input  wire logic  clock,
    // Pin levels toward the device
    output logic [4:0] strap_pins,
    output logic       chip_enable_in
);
    // Rails up at time zero, enable held off
    initial begin
        strap_pins     = RSL_STRAP_RESET;
        chip_enable_in = 1'b0;
    end

    // Strap levels stay put through the release edge
    task automatic set_straps(input logic [4:0] v);
        strap_pins <= v;
    endtask

    // Hold enable low for n rising edges; a reset only if n is long enough to qualify
    task automatic hold_low(input int n);
        chip_enable_in <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    // Raise enable only after the settling wait
    task automatic release_enable(input int wait_cycles);
        repeat (wait_cycles) @(posedge clock);
        chip_enable_in <= 1'b1;
    endtask
endmodule // rsl_board_model

/* File: verif/tb_top.sv */
/*
 Self-checking bench for the reset strap latch, with a board model.
 Assumes a 200 MHz clock and a shortened chip-enable qualify count of 4.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
    import rsl_pkg::*;
;
    logic        clock;
    logic        rst;
    logic        wdt_reset;
    logic        brownout_reset;
    logic [4:0]  strap_pins;       // Pin levels from the board
    logic        chip_enable_in;
    logic [4:0]  pull_up_en;
    logic [4:0]  pull_down_en;
    logic        pins_functional;
    rsl_ctrl_s   ctrl;
    logic [4:0]  strap_status;
    rsl_cfg_s    cfg;
    logic        in_reset;
    logic        log_tx_data;
    logic        boot_done;        // Raised briefly per pass to end the log window
    logic        first_serial_tx;
    int          fail_count = 0;
    int          num_checks = 0;
    int          seed = 32'hB263;
    logic [4:0]  latch_q[$];       // Model: latched word per release
    logic [31:0] r;

    rsl_board_model board (.clock(clock), .strap_pins(strap_pins),
                           .chip_enable_in(chip_enable_in));

    rsl_strap_latch #(.CE_LOW_CYCLES(4)) dut (
        .clock(clock), .rst(rst), .chip_enable_in(chip_enable_in),
        .wdt_reset(wdt_reset), .brownout_reset(brownout_reset),
        .ldo_voltage_strap(strap_pins[0]), .primary_boot_strap(strap_pins[1]),
        .secondary_boot_strap(strap_pins[2]), .log_timing_strap(strap_pins[3]),
        .sdio_edge_strap(strap_pins[4]), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .pins_functional(pins_functional),
        .ctrl(ctrl), .strap_status(strap_status), .cfg(cfg), .in_reset(in_reset),
        .log_tx_data(log_tx_data), .boot_done(boot_done),
        .first_serial_tx(first_serial_tx));

    // 5 ns clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Advance n rising edges
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait for the system reset to drop
    task automatic wait_release();
        int n;
        n = 0;
        while (in_reset !== 1'b0 && n < 50) begin
            cyc(1);
            n++;
        end
        if (n >= 50) begin
            fail_count++;
            close_out();
        end
    endtask

    // Expected decode from the model's latched word and the controls
    task automatic check_cfg(input rsl_ctrl_s c);
        logic [4:0] s;
        logic       lv;
        logic [1:0] ed;
        rsl_boot_e  b;
        s  = latch_q[$];
        lv = c.ldo_ovr_en ? c.ldo_ovr_1v8 : s[0];
        ed = c.sdio_ovr_en ? c.sdio_ovr_edges : {s[3], s[4]};
        b  = s[1] ? RSL_BOOT_FLASH : (s[2] ? RSL_BOOT_INVALID : RSL_BOOT_DOWNLOAD);
        `CHK(cfg.boot_src, b)
        `CHK(cfg.ldo_level, lv ? RSL_LDO_1V8 : RSL_LDO_3V3)
        `CHK(cfg.ldo_enable, ~c.ldo_power_off)
        `CHK(cfg.log_enable, s[3])
        `CHK({cfg.sdio_sample_rising, cfg.sdio_output_rising}, ed)
    endtask

    // Main sequence: one reset cause per pass, rotating
    initial begin
        rst = 1'b1;
        wdt_reset = 1'b0;
        brownout_reset = 1'b0;
        ctrl = '0;
        log_tx_data = 1'b1;
        boot_done = 1'b0;
        cyc(3);
        rst <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            // Every pass starts its stimulus on a rising edge
            cyc(1);
            r = $random(seed);
            board.set_straps(r[4:0]);
            ctrl <= '0;
            // Pass 0 is power-up, chip enable already low
            case (i % 3)
                0: board.hold_low(8);
                1: begin wdt_reset <= 1'b1; cyc(8); end
                default: begin brownout_reset <= 1'b1; cyc(8); end
            endcase
            @(negedge clock);
            `CHK(in_reset, 1'b1)
            `CHK(pull_up_en, RSL_PULL_UP_MASK)
            `CHK(pull_down_en, ~RSL_PULL_UP_MASK)
            cyc(1);
            wdt_reset <= 1'b0;
            brownout_reset <= 1'b0;
            latch_q.push_back(r[4:0]);
            board.release_enable(i == 0 ? RSL_CE_LOW_CYCLES : 0);
            wait_release();
            cyc(3);
            @(negedge clock);
            `CHK(strap_status, latch_q[$])
            `CHK({pull_up_en, pull_down_en}, 10'h000)
            `CHK(pins_functional, 1'b1)
            check_cfg('0);
            // Random overrides, power-off included
            cyc(1);
            r = $random(seed);
            ctrl <= r[5:0];
            cyc(3);
            @(negedge clock);
            check_cfg(ctrl);
            // Pin activity and a too-short enable dip must not disturb the latch
            cyc(1);
            board.set_straps(~latch_q[$]);
            board.hold_low(2);
            board.release_enable(0);
            log_tx_data <= 1'b0;
            cyc(3);
            @(negedge clock);
            `CHK(in_reset, 1'b0)
            `CHK(strap_status, latch_q[$])
            `CHK(first_serial_tx, ~latch_q[$][3])
            cyc(1);
            log_tx_data <= 1'b1;
            cyc(3);
            @(negedge clock);
            `CHK(first_serial_tx, 1'b1)
            // Boot over: the line carries traffic whatever the log strap
            cyc(1);
            boot_done   <= 1'b1;
            log_tx_data <= 1'b0;
            cyc(3);
            @(negedge clock);
            `CHK(first_serial_tx, 1'b0)
            cyc(1);
            boot_done   <= 1'b0;
            log_tx_data <= 1'b1;
            $display("pass %0d done, status %h", i, strap_status);
        end
        close_out();
    end
endmodule // tb_top
